// *** core/tcp_param_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_param_decode
	import tcp_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	input wire logic i_ref_clk, // module clock, 10 MHz
	input wire logic i_rst, // async reset, high
	input wire logic i_par_wr, // parameter byte write strobe
	input wire logic i_par_rd, // parameter byte read strobe
	input wire logic [7:0] i_par_idx, // byte position in record
	input wire logic [7:0] i_par_wdata, // byte written
	input wire logic i_sys_stopped, // controlling system in stop state
	input wire logic i_diag_event, // diagnostic event pulse
	input wire logic [CHANNELS-1:0] i_wire_break_raw, // raw open-wire detect
	input wire logic [CHANNELS-1:0] i_sample_valid, // new sample per channel
	input wire logic [CHANNELS*SAMPLE_W-1:0] i_sample_uv, // samples, microvolts
	output logic [7:0] o_par_rdata, // read data, registered
	output logic o_par_rvalid, // read data valid pulse
	output logic o_stop_violation, // protected byte written while running
	output tcp_cfg_t o_cfg, // decoded configuration
	output logic [CHANNELS-1:0] o_ch_active, // channel measures
	output logic [CHANNELS*8-1:0] o_ch_func, // function codes
	output logic [CHANNELS-1:0] o_wire_break, // gated wire-break flags
	output logic [CHANNELS-1:0] o_limit_active, // limit check enable
	output logic o_diag_irq, // diagnostic interrupt pulse
	output tcp_result_t [CHANNELS-1:0] o_result // scaled millivolt results
);

	logic [7:0] diag_byte;
	logic [1:0] wire_break_enables;
	logic [1:0] limit_monitor_enables;
	tcp_unit_t temperature_unit_select;
	tcp_mains_t mains_rejection_select;
	logic [7:0] channel_function_code [CHANNELS];
	logic [CHANNELS-1:0] wire_break_seen;
	logic [CHANNELS-1:0] next_wire_break;
	logic wr_protected;

	// diagnostic gate: only the two documented codes change it
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			diag_byte <= RST_DIAG;
		end else if (i_par_wr && i_par_idx == OFS_DIAG) begin
			if (i_par_wdata == DIAG_ON || i_par_wdata == DIAG_OFF) begin
				diag_byte <= i_par_wdata;
			end
		end
	end

	// enable bytes keep bits 1:0 only
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wire_break_enables <= RST_WIRE_BREAK[1:0];
			limit_monitor_enables <= RST_LIMIT[1:0];
		end else if (i_par_wr) begin
			if (i_par_idx == OFS_WIRE_BREAK) begin
				wire_break_enables <= i_par_wdata[SEL_LSB +: SEL_W] & ENABLE_MASK;
			end
			if (i_par_idx == OFS_LIMIT) begin
				limit_monitor_enables <= i_par_wdata[SEL_LSB +: SEL_W] & ENABLE_MASK;
			end
		end
	end

	// undefined selector codes are dropped so the unit or filter never goes undefined
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			temperature_unit_select <= tcp_unit_t'(RST_TEMP_UNIT[1:0]);
			mains_rejection_select <= tcp_mains_t'(RST_MAINS[1:0]);
		end else if (i_par_wr) begin
			if (i_par_idx == OFS_TEMP_UNIT) begin
				unique case (i_par_wdata[SEL_LSB +: SEL_W])
					2'h0: temperature_unit_select <= UNIT_CELSIUS;
					2'h1: temperature_unit_select <= UNIT_FAHRENHEIT;
					2'h2: temperature_unit_select <= UNIT_KELVIN;
					default: temperature_unit_select <= temperature_unit_select;
				endcase
			end
			if (i_par_idx == OFS_MAINS) begin
				unique case (i_par_wdata[SEL_LSB +: SEL_W])
					2'h1: mains_rejection_select <= MAINS_60HZ;
					2'h2: mains_rejection_select <= MAINS_50HZ;
					default: mains_rejection_select <= mains_rejection_select;
				endcase
			end
		end
	end

	// function code byte sits every six bytes
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int c = 0; c < CHANNELS; c++) begin
				channel_function_code[c] <= RST_FUNC;
			end
		end else if (i_par_wr) begin
			for (int c = 0; c < CHANNELS; c++) begin
				if (i_par_idx == 8'(OFS_CH0_FUNC + c * (OFS_CH1_FUNC - OFS_CH0_FUNC))) begin
					channel_function_code[c] <= i_par_wdata;
				end
			end
		end
	end

	// stop-state bytes: the host is expected to honour this; we only flag a breach
	always_comb begin
		wr_protected = i_par_wr && (i_par_idx == OFS_DIAG || i_par_idx == OFS_WIRE_BREAK ||
			i_par_idx == OFS_LIMIT || i_par_idx == OFS_RESERVED3);
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_stop_violation <= 1'b0;
		end else begin
			o_stop_violation <= wr_protected && !i_sys_stopped;
		end
	end

	// readback of the stored view, reserved bits as zero
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_par_rdata <= 8'h00;
			o_par_rvalid <= 1'b0;
		end else begin
			o_par_rvalid <= i_par_rd;
			if (i_par_rd) begin
				o_par_rdata <= 8'h00;
				if (i_par_idx == OFS_DIAG) begin
					o_par_rdata <= diag_byte;
				end else if (i_par_idx == OFS_WIRE_BREAK) begin
					o_par_rdata <= {6'h00, wire_break_enables};
				end else if (i_par_idx == OFS_LIMIT) begin
					o_par_rdata <= {6'h00, limit_monitor_enables};
				end else if (i_par_idx == OFS_TEMP_UNIT) begin
					o_par_rdata <= {6'h00, temperature_unit_select};
				end else if (i_par_idx == OFS_MAINS) begin
					o_par_rdata <= {6'h00, mains_rejection_select};
				end
				for (int c = 0; c < CHANNELS; c++) begin
					if (i_par_idx == 8'(OFS_CH0_FUNC + c * (OFS_CH1_FUNC - OFS_CH0_FUNC))) begin
						o_par_rdata <= channel_function_code[c];
					end
				end
			end
		end
	end

	always_comb begin
		o_cfg.diag_irq_en = (diag_byte == DIAG_ON);
		o_cfg.wire_break_en = wire_break_enables;
		o_cfg.limit_en = limit_monitor_enables;
		o_cfg.unit = temperature_unit_select;
		o_cfg.mains = mains_rejection_select;
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic [7:0] ch_func;
			logic ch_on;

			assign ch_func = channel_function_code[g];
			assign ch_on = (ch_func != FUNC_OFF);
			assign o_ch_active[g] = ch_on;
			assign o_ch_func[g*8 +: 8] = ch_func;
			assign o_limit_active[g] = ch_on && limit_monitor_enables[g];
			assign next_wire_break[g] = ch_on && wire_break_enables[g] && i_wire_break_raw[g];

			tcp_mv_scaler u_scaler (
				.i_ref_clk(i_ref_clk),
				.i_rst(i_rst),
				.i_func(ch_func),
				.i_sample_valid(i_sample_valid[g] && ch_on),
				.i_sample_uv(i_sample_uv[g*SAMPLE_W +: SAMPLE_W]),
				.o_result(o_result[g])
			);
		end
	endgenerate

	// wire-break flags registered; a new break raises a diagnostic
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wire_break_seen <= '0;
		end else begin
			wire_break_seen <= next_wire_break;
		end
	end

	assign o_wire_break = wire_break_seen;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_diag_irq <= 1'b0;
		end else begin
			o_diag_irq <= o_cfg.diag_irq_en &&
				(i_diag_event || |(next_wire_break & ~wire_break_seen));
		end
	end

endmodule : tcp_param_decode
`default_nettype wire

// *** core/tcp_pkg.sv ***
package tcp_pkg;

	// byte positions inside the parameter record
	localparam logic [7:0] OFS_DIAG = 8'h00;
	localparam logic [7:0] OFS_WIRE_BREAK = 8'h01;
	localparam logic [7:0] OFS_LIMIT = 8'h02;
	localparam logic [7:0] OFS_RESERVED3 = 8'h03;
	localparam logic [7:0] OFS_TEMP_UNIT = 8'h04;
	localparam logic [7:0] OFS_MAINS = 8'h05;
	localparam logic [7:0] OFS_CH0_FUNC = 8'h06;
	localparam logic [7:0] OFS_CH1_FUNC = 8'h0C;

	// reset values
	localparam logic [7:0] RST_DIAG = 8'h00;
	localparam logic [7:0] RST_WIRE_BREAK = 8'h00;
	localparam logic [7:0] RST_LIMIT = 8'h00;
	localparam logic [7:0] RST_TEMP_UNIT = 8'h00;
	localparam logic [7:0] RST_MAINS = 8'h02;
	localparam logic [7:0] RST_FUNC = 8'hC1;

	// field codes
	localparam logic [7:0] DIAG_ON = 8'h00;
	localparam logic [7:0] DIAG_OFF = 8'h40;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 2;
	localparam logic [1:0] ENABLE_MASK = 2'h3;
	localparam logic [7:0] FUNC_OFF = 8'hFF;
	localparam logic [7:0] FUNC_MV_27K = 8'h11;
	localparam logic [7:0] FUNC_MV_16K = 8'h21;

	typedef enum logic [1:0] {
		UNIT_CELSIUS = 2'b00,
		UNIT_FAHRENHEIT = 2'b01,
		UNIT_KELVIN = 2'b10
	} tcp_unit_t;

	typedef enum logic [1:0] {
		MAINS_60HZ = 2'b01,
		MAINS_50HZ = 2'b10
	} tcp_mains_t;

	// scaling: sample arrives in microvolts
	localparam int SAMPLE_W = 18;
	localparam int PROD_W = 34;
	localparam logic signed [PROD_W-1:0] FULL_SCALE_UV = 34'sh0_0001_3880;
	localparam logic signed [PROD_W-1:0] GAIN_27K = 34'sh0_0000_6C00;
	localparam logic signed [PROD_W-1:0] GAIN_16K = 34'sh0_0000_4000;
	localparam logic signed [15:0] K27_OVER = 16'sh7EFF;
	localparam logic signed [15:0] K27_UNDER = 16'sh8100;
	localparam logic signed [15:0] K16_OVER = 16'sh5000;
	localparam logic signed [15:0] K16_UNDER = 16'shB000;

	typedef struct packed {
		logic diag_irq_en;
		logic [1:0] wire_break_en;
		logic [1:0] limit_en;
		tcp_unit_t unit;
		tcp_mains_t mains;
	} tcp_cfg_t;

	typedef struct packed {
		logic valid;
		logic signed [15:0] value;
		logic over;
		logic under;
	} tcp_result_t;

endpackage : tcp_pkg

// *** core/tcp_mv_scaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_mv_scaler
	import tcp_pkg::*;
(
	input wire logic i_ref_clk, // module clock
	input wire logic i_rst, // async reset, high
	input wire logic [7:0] i_func, // channel function code
	input wire logic i_sample_valid, // new sample strobe
	input wire logic signed [SAMPLE_W-1:0] i_sample_uv, // input voltage, microvolts
	output tcp_result_t o_result // scaled value, registered
);

	logic signed [PROD_W-1:0] prod;
	logic signed [PROD_W-1:0] quot;
	logic signed [15:0] hi_lim;
	logic signed [15:0] lo_lim;
	logic is_mv;
	tcp_result_t next_result;

	always_comb begin
		is_mv = (i_func == FUNC_MV_27K) || (i_func == FUNC_MV_16K);
		if (i_func == FUNC_MV_16K) begin
			prod = PROD_W'(i_sample_uv) * GAIN_16K;
			hi_lim = K16_OVER;
			lo_lim = K16_UNDER;
		end else begin
			prod = PROD_W'(i_sample_uv) * GAIN_27K;
			hi_lim = K27_OVER;
			lo_lim = K27_UNDER;
		end
		// truncation toward zero keeps the scale symmetric about 0 V
		quot = prod / FULL_SCALE_UV;
		next_result.valid = i_sample_valid && is_mv;
		next_result.over = quot > PROD_W'(hi_lim);
		next_result.under = quot < PROD_W'(lo_lim);
		if (next_result.over) begin
			next_result.value = hi_lim;
		end else if (next_result.under) begin
			next_result.value = lo_lim;
		end else begin
			next_result.value = quot[15:0];
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_result <= '0;
		end else if (i_sample_valid) begin
			o_result <= next_result;
		end else begin
			o_result.valid <= 1'b0;
		end
	end

endmodule : tcp_mv_scaler
`default_nettype wire

// *** bench/tcp_param_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_param_props
	import tcp_pkg::*;
#(
	parameter int CHANNELS = 2
) (
	input wire logic i_ref_clk, // clock
	input wire logic i_rst, // reset
	input wire logic i_par_wr, // write strobe
	input wire logic i_par_rd, // read strobe
	input wire logic [7:0] i_par_idx, // byte position
	input wire logic [7:0] i_par_wdata, // write byte
	input wire logic i_diag_event, // diag event
	input wire logic [CHANNELS-1:0] i_wire_break_raw, // raw open wire
	input wire logic o_par_rvalid, // read valid
	input wire tcp_cfg_t o_cfg, // config
	input wire logic [CHANNELS-1:0] o_ch_active, // active
	input wire logic [CHANNELS*8-1:0] o_ch_func, // function codes
	input wire logic [CHANNELS-1:0] o_wire_break, // gated break
	input wire logic [CHANNELS-1:0] o_limit_active, // limit enable
	input wire logic o_diag_irq, // diag pulse
	input wire tcp_result_t [CHANNELS-1:0] o_result // results
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	wire wr_unit = i_par_wr && i_par_idx == OFS_TEMP_UNIT && i_par_wdata[1:0] != 2'h3;
	wire wr_mains = i_par_wr && i_par_idx == OFS_MAINS && i_par_wdata[1:0] inside {2'h1, 2'h2};
	property p_rvalid; i_par_rd |=> o_par_rvalid ##1 !o_par_rvalid || $past(i_par_rd, 1); endproperty
	property p_diag_off; i_par_wr && i_par_idx == OFS_DIAG && i_par_wdata == DIAG_OFF |=> !o_cfg.diag_irq_en; endproperty
	property p_irq; i_diag_event && o_cfg.diag_irq_en |=> o_diag_irq; endproperty
	property p_irq_gate; !o_cfg.diag_irq_en |=> !o_diag_irq; endproperty
	property p_wb; ##1 1'b1 |-> o_wire_break == ($past(i_wire_break_raw) & $past(o_cfg.wire_break_en) & $past(o_ch_active)); endproperty
	property p_limit; o_limit_active == (o_cfg.limit_en & o_ch_active); endproperty
	property p_unit; wr_unit |=> o_cfg.unit == $past(i_par_wdata[1:0]); endproperty
	property p_mains; wr_mains |=> o_cfg.mains == $past(i_par_wdata[1:0]); endproperty
	property p_active; o_ch_active == {o_ch_func[15:8] != FUNC_OFF, o_ch_func[7:0] != FUNC_OFF}; endproperty
	property p_off; !o_ch_active[1] |=> !o_result[1].valid && $stable(o_result[1].value); endproperty
	a_rvalid: assert property (p_rvalid) else $error("read valid late or stuck");
	a_diag_off: assert property (p_diag_off) else $error("diag gate not cleared");
	a_irq: assert property (p_irq) else $error("diag pulse missing");
	a_irq_gate: assert property (p_irq_gate) else $error("diag pulse while gated");
	a_wb: assert property (p_wb) else $error("wire break gating wrong");
	a_limit: assert property (p_limit) else $error("limit enable wrong");
	a_unit: assert property (p_unit) else $error("unit select wrong");
	a_mains: assert property (p_mains) else $error("mains select wrong");
	a_active: assert property (p_active) else $error("channel active wrong");
	a_off: assert property (p_off) else $error("result from inactive channel");
	c_irq: cover property (o_diag_irq);
	c_over: cover property (o_result[0].valid && o_result[0].over);
	c_under: cover property (o_result[0].valid && o_result[0].under);
endmodule : tcp_param_props
`default_nettype wire

// *** bench/tcp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_host_model (
	input wire logic i_ref_clk, // clock
	input wire logic [7:0] i_rdata, // read byte
	input wire logic i_rvalid, // read valid
	output logic o_wr = 1'b0, // write strobe
	output logic o_rd = 1'b0, // read strobe
	output logic [7:0] o_idx = 8'h00, // byte position
	output logic [7:0] o_wdata = 8'h00, // write byte
	output logic o_stopped = 1'b1 // controller stopped
);
	// protected bytes go out only while stopped unless a test clears it
	task automatic run(input logic s);
		@(negedge i_ref_clk);
		o_stopped = s;
	endtask : run
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_wr = 1'b1;
		o_idx = idx;
		o_wdata = d;
		@(negedge i_ref_clk);
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic v);
		@(negedge i_ref_clk);
		o_rd = 1'b1;
		o_idx = idx;
		@(negedge i_ref_clk);
		o_rd = 1'b0;
		o_idx = ~idx;
		v = i_rvalid;
		d = i_rdata;
	endtask : rd
endmodule : tcp_host_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb;
	import tcp_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_diag_event = 1'b0;
	logic [1:0] i_wire_break_raw = 2'h0;
	logic [1:0] i_sample_valid = 2'h0;
	logic [35:0] i_sample_uv = 36'h0;
	logic wr, rd, stopped, rvalid, stop_v, irq, v;
	logic [7:0] idx, wd, rdata, d;
	tcp_cfg_t cfg;
	logic [1:0] act, wb, lim;
	logic [15:0] fn;
	tcp_result_t [1:0] res;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [7:0] ri[6] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h0C, 8'h20};
	logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h02, 8'hC1, 8'hC1, 8'h00};
	logic [7:0] tf[9] = '{8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h21, 8'h21, 8'h21, 8'h21};
	int tu[9] = '{80000, -80000, 0, 100000, -100000, 80000, -80000, 120000, -120000};
	logic [15:0] te[9] = '{16'h6C00, 16'h9400, 16'h0000, 16'h7EFF, 16'h8100, 16'h4000, 16'hC000, 16'h5000, 16'hB000};
	logic [1:0] tou[9] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h2, 2'h1};
	always #50 i_ref_clk = ~i_ref_clk;
	tcp_host_model host_u (.i_ref_clk, .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr), .o_rd(rd), .o_idx(idx),
		.o_wdata(wd), .o_stopped(stopped));
	tcp_param_decode #(.CHANNELS(2)) dut_u (.i_ref_clk, .i_rst, .i_par_wr(wr), .i_par_rd(rd), .i_par_idx(idx),
		.i_par_wdata(wd), .i_sys_stopped(stopped), .i_diag_event, .i_wire_break_raw, .i_sample_valid, .i_sample_uv,
		.o_par_rdata(rdata), .o_par_rvalid(rvalid), .o_stop_violation(stop_v), .o_cfg(cfg), .o_ch_active(act),
		.o_ch_func(fn), .o_wire_break(wb), .o_limit_active(lim), .o_diag_irq(irq), .o_result(res));
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic pulse_event;
		@(negedge i_ref_clk);
		i_diag_event = 1'b1;
		@(negedge i_ref_clk);
		i_diag_event = 1'b0;
	endtask : pulse_event
	task automatic samp(input int ch, input int uv);
		@(negedge i_ref_clk);
		i_sample_valid[ch] = 1'b1;
		i_sample_uv[ch*18+:18] = uv[17:0];
		@(negedge i_ref_clk);
		i_sample_valid = 2'h0;
		i_sample_uv = ~i_sample_uv;
	endtask : samp
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		repeat (10) @(negedge i_ref_clk);
		i_rst = 1'b0;
		for (int k = 0; k < 6; k++) begin
			host_u.rd(ri[k], d, v);
			`CK("reset byte", rv[k], d)
			`CK("read valid", 1'b1, v)
		end
		$display("test reset done");
		host_u.wr(OFS_DIAG, DIAG_OFF);
		`CK("diag off", 1'b0, cfg.diag_irq_en)
		pulse_event();
		`CK("irq gated", 1'b0, irq)
		host_u.wr(OFS_DIAG, DIAG_ON);
		pulse_event();
		`CK("irq raised", 1'b1, irq)
		$display("test diag done");
		i_wire_break_raw = 2'h3;
		host_u.wr(OFS_WIRE_BREAK, 8'hFD);
		@(negedge i_ref_clk);
		`CK("wire break", 2'h1, wb)
		host_u.rd(OFS_WIRE_BREAK, d, v);
		`CK("wire break byte", 8'h01, d)
		host_u.wr(OFS_LIMIT, 8'hFE);
		`CK("limit", 2'h2, lim)
		host_u.run(1'b0);
		host_u.wr(OFS_LIMIT, 8'h01);
		`CK("stop flag", 1'b1, stop_v)
		host_u.run(1'b1);
		$display("test enables done");
		for (int u = 0; u < 4; u++) begin
			host_u.wr(OFS_TEMP_UNIT, {6'h3F, u[1:0]});
			`CK("unit", (u == 3) ? 2'h2 : u[1:0], cfg.unit)
		end
		for (int m = 1; m < 4; m++) begin
			host_u.wr(OFS_MAINS, {6'h2A, m[1:0]});
			`CK("mains", (m == 3) ? 2'h2 : m[1:0], cfg.mains)
		end
		$display("test select done");
		for (int k = 0; k < 9; k++) begin
			host_u.wr(OFS_CH0_FUNC, tf[k]);
			samp(0, tu[k]);
			`CK("valid", 1'b1, res[0].valid)
			`CK("value", te[k], res[0].value)
			`CK("range", tou[k], {res[0].over, res[0].under})
		end
		$display("test scale done");
		host_u.wr(OFS_CH1_FUNC, FUNC_OFF);
		`CK("active", 2'h1, act)
		samp(1, 80000);
		`CK("off valid", 1'b0, res[1].valid)
		`CK("off value", 16'h0000, res[1].value)
		$display("test off done");
		close_out();
	end
endmodule : tb
bind tcp_param_decode tcp_param_props #(.CHANNELS(CHANNELS)) props_u (.i_ref_clk, .i_rst, .i_par_wr, .i_par_rd,
	.i_par_idx, .i_par_wdata, .i_diag_event, .i_wire_break_raw, .o_par_rvalid, .o_cfg, .o_ch_active, .o_ch_func,
	.o_wire_break, .o_limit_active, .o_diag_irq, .o_result);
`default_nettype wire
